//--- rtl/tmi_pkg.sv
package tmi_pkg;

    // Register layout as seen from the serial host.
    localparam int            REG_W          = 8;
    localparam logic [7:0]    REG_MASK_ADDR  = 8'h0c;
    localparam logic [7:0]    REG_STAT_ADDR  = 8'h0d;
    localparam logic [7:0]    REG_FLAG_ADDR  = 8'h0e;
    localparam logic [7:0]    MASK_RESET     = 8'h00;
    localparam logic [7:0]    FLAG_RESET     = 8'h00;

    // Bit positions in the status register; SHDN and WARN are shared with mask and flag.
    localparam int            BIT_SHDN       = 0;
    localparam int            BIT_WARN       = 1;
    localparam int            BIT_LATCH      = 2;
    localparam int            BIT_IRQ_LINE   = 3;
    localparam logic [7:0]    FLAG_USED      = 8'h03;

    // Serial framing.
    localparam logic [3:0]    BYTE_BITS      = 4'h8;
    localparam logic [6:0]    DEV_ADDR_DFLT  = 7'h2a;

    // Logic clock: the internal oscillator, nominal 2.0 MHz in the device.
    localparam int            OSC_FREQ_KHZ   = 2000;
    localparam int            MCLK_FREQ_MHZ  = 125;

    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_REG,
        ST_REG_ACK,
        ST_WDATA,
        ST_WDATA_ACK,
        ST_RDATA,
        ST_RDATA_ACK
    } tmi_i2c_st_t;

endpackage

//--- rtl/tmi_sync.sv
`timescale 1ns/1ns
module tmi_sync #(
    parameter int W = 1
) (
    input  wire logic         MCLK,
    input  wire logic         RST,
    input  wire logic [W-1:0] async_in,
    output logic      [W-1:0] sync_out
);
    import tmi_pkg::*;

    logic [W-1:0] meta_q;

    // Each bit is an independent level; no bus coherency is implied.
    for (genvar i = 0; i < W; i++) begin : g_bit
        always_ff @(posedge MCLK) begin
            if (RST) begin
                meta_q[i]   <= 1'b0;
                sync_out[i] <= 1'b0;
            end else begin
                meta_q[i]   <= async_in[i];
                sync_out[i] <= meta_q[i];
            end
        end
    end

endmodule

//--- rtl/tmi_trip.sv
`timescale 1ns/1ns
module tmi_trip (
    input  wire logic MCLK,
    input  wire logic RST,
    input  wire logic warn_lvl,
    input  wire logic shdn_lvl,
    input  wire logic cool_lvl,
    input  wire logic pwr_req_lvl,
    output logic      warn_rise,
    output logic      shdn_rise,
    output logic      shutdown_q,
    output logic      pwr_go_q
);
    import tmi_pkg::*;

    logic warn_d_q;
    logic shdn_d_q;
    logic req_d_q;
    logic req_rise;

    always_ff @(posedge MCLK) begin
        if (RST) begin
            warn_d_q <= 1'b0;
            shdn_d_q <= 1'b0;
            req_d_q  <= 1'b0;
        end else begin
            warn_d_q <= warn_lvl;
            shdn_d_q <= shdn_lvl;
            req_d_q  <= pwr_req_lvl;
        end
    end

    assign warn_rise = warn_lvl & ~warn_d_q;
    assign shdn_rise = shdn_lvl & ~shdn_d_q;
    assign req_rise  = pwr_req_lvl & ~req_d_q;

    // A refused request is dropped; the host has to raise it again once cool.
    always_ff @(posedge MCLK) begin
        if (RST) begin
            shutdown_q <= 1'b0;
            pwr_go_q   <= 1'b0;
        end else begin
            pwr_go_q <= req_rise & ~shdn_lvl & (~shutdown_q | cool_lvl); // [RL8]
            if (shdn_rise) begin
                shutdown_q <= 1'b1; // [RL7]
            end else if (req_rise && shutdown_q && cool_lvl) begin
                shutdown_q <= 1'b0; // [RL8]
            end
        end
    end

    AST_SHDN_STARTS: assert property (@(posedge MCLK) disable iff (RST) // [RL7]
        shdn_rise |=> shutdown_q && !pwr_go_q)
        else $error("Shutdown trip did not start emergency shutdown.");

    AST_NO_HOT_POWERUP: assert property (@(posedge MCLK) disable iff (RST) // [RL8]
        (shutdown_q && !cool_lvl) |=> !pwr_go_q)
        else $error("Power-up started while still hot after shutdown.");

endmodule

//--- rtl/tmi_top.sv
`timescale 1ns/1ns
// Contract
// RL1 - Every read of the interrupt flag register clears all its bits; the code clears only the bits captured at byte load.
// RL2 - Reading the flag register releases the interrupt request line.
// RL3 - Shutdown mask bit at 0x0C set to 1 suppresses shutdown interrupt.
// RL4 - Warning mask bit set to 1 suppresses the early-warning interrupt.
// RL5 - Warning flag reads 0 when no early-warning interrupt is pending.
// RL6 - Crossing warning threshold pulls request low and sets status and flag bits.
// RL7 - Crossing shutdown threshold starts an emergency shutdown.
// RL8 - After shutdown, power-up is refused until cooled to the cool threshold.
// RL9 - Control logic runs from the internal oscillator clock.
// RL10 - Request line and serial data are open-drain, driven only low.
// RL11 - Masked events still record flags but never pull the request low.
// RL12 - Host reads the flag register after the request asserts.
module tmi_top #(
    parameter logic [6:0] DEV_ADDR = tmi_pkg::DEV_ADDR_DFLT
) (
    input  wire logic MCLK,
    input  wire logic RST,
    input  wire logic SCL_I,
    input  wire logic SDA_I,
    output logic      SDA_O,
    output logic      SDA_OE,
    input  wire logic IRQ_N_I,
    output logic      IRQ_N_O,
    output logic      IRQ_N_OE,
    input  wire logic HOT_WARN,
    input  wire logic HOT_TRIP,
    input  wire logic COOL_OK,
    input  wire logic PWR_UP_REQ,
    output logic      PWR_UP_GO,
    output logic      EMERG_SHDN
);
    import tmi_pkg::*;

    // DEV_ADDR default is an arbitrary value.

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisation and thermal tracking.

    logic [5:0]  pins_s;
    logic        scl_s;
    logic        sda_s;
    logic        irq_line_s;
    logic        warn_s;
    logic        shdn_s;
    logic        cool_s;
    logic        req_s;
    logic        warn_rise;
    logic        shdn_rise;
    logic        shutdown_q;
    logic        pwr_go_q;

    // MCLK stands in for the internal oscillator that clocks all control logic. [RL9]
    tmi_sync #(
        .W (6)
    ) u_sync (
        .MCLK     (MCLK),
        .RST      (RST),
        .async_in ({PWR_UP_REQ, COOL_OK, HOT_TRIP, HOT_WARN, ~IRQ_N_I, ~SCL_I}),
        .sync_out (pins_s)
    );

    // Idle-high pins enter the shared pair inverted so reset shows no false edge; SDA has its own pair.
    logic sda_meta_q;
    logic sda_sync_q;
    always_ff @(posedge MCLK) begin
        if (RST) begin
            sda_meta_q <= 1'b1;
            sda_sync_q <= 1'b1;
        end else begin
            sda_meta_q <= SDA_I;
            sda_sync_q <= sda_meta_q;
        end
    end

    assign scl_s      = ~pins_s[0];
    assign irq_line_s = ~pins_s[1];
    assign warn_s     = pins_s[2];
    assign shdn_s     = pins_s[3];
    assign cool_s     = pins_s[4];
    assign req_s      = pins_s[5];
    assign sda_s      = sda_sync_q;

    tmi_trip u_trip (
        .MCLK        (MCLK),
        .RST         (RST),
        .warn_lvl    (warn_s),
        .shdn_lvl    (shdn_s),
        .cool_lvl    (cool_s),
        .pwr_req_lvl (req_s),
        .warn_rise   (warn_rise),
        .shdn_rise   (shdn_rise),
        .shutdown_q  (shutdown_q),
        .pwr_go_q    (pwr_go_q)
    );

    assign PWR_UP_GO  = pwr_go_q;
    assign EMERG_SHDN = shutdown_q;

    ////////////////////////////////////////////////////////////////////////
    // Serial bus condition detection.

    logic scl_d_q;
    logic sda_d_q;
    logic scl_rise;
    logic scl_fall;
    logic i2c_start;
    logic i2c_stop;
    logic ev_ok;

    always_ff @(posedge MCLK) begin
        if (RST) begin
            scl_d_q <= 1'b1;
            sda_d_q <= 1'b1;
        end else begin
            scl_d_q <= scl_s;
            sda_d_q <= sda_s;
        end
    end

    assign scl_rise  = scl_s & ~scl_d_q;
    assign scl_fall  = ~scl_s & scl_d_q;
    assign i2c_start = scl_s & scl_d_q & sda_d_q & ~sda_s;
    assign i2c_stop  = scl_s & scl_d_q & ~sda_d_q & sda_s;
    assign ev_ok     = ~i2c_start & ~i2c_stop;

    ////////////////////////////////////////////////////////////////////////
    // Serial slave state machine.

    tmi_i2c_st_t st_q;
    logic [3:0]  cnt_q;
    logic [7:0]  shift_q;
    logic [7:0]  ptr_q;
    logic        rw_q;
    logic        mack_q;
    logic        sda_drv_q;
    logic [7:0]  rd_byte;
    logic        load_p;
    logic        wr_p;
    logic        rd_done_p;
    logic        byte_end;

    assign byte_end  = scl_fall && (cnt_q == BYTE_BITS) && ev_ok;
    assign load_p    = ev_ok && scl_fall && ((st_q == ST_ADDR_ACK && rw_q) || (st_q == ST_RDATA_ACK && mack_q));
    assign wr_p      = byte_end && (st_q == ST_WDATA);

    always_ff @(posedge MCLK) begin
        if (RST) begin
            st_q      <= ST_IDLE;
            cnt_q     <= 4'h0;
            shift_q   <= 8'h00;
            ptr_q     <= 8'h00;
            rw_q      <= 1'b0;
            mack_q    <= 1'b0;
            sda_drv_q <= 1'b0;
        end else if (i2c_stop) begin
            st_q      <= ST_IDLE;
            sda_drv_q <= 1'b0;
        end else if (i2c_start) begin
            st_q      <= ST_ADDR;
            cnt_q     <= 4'h0;
            sda_drv_q <= 1'b0;
        end else begin
            unique case (st_q)
                ST_IDLE: begin
                    sda_drv_q <= 1'b0;
                end
                ST_ADDR, ST_REG, ST_WDATA: begin
                    if (scl_rise && cnt_q != BYTE_BITS) begin
                        shift_q <= {shift_q[6:0], sda_s};
                        cnt_q   <= cnt_q + 4'h1;
                    end else if (byte_end) begin
                        cnt_q <= 4'h0;
                        if (st_q == ST_ADDR && shift_q[7:1] != DEV_ADDR) begin
                            st_q <= ST_IDLE;
                        end else begin
                            sda_drv_q <= 1'b1;
                            if (st_q == ST_ADDR) begin
                                rw_q <= shift_q[0];
                                st_q <= ST_ADDR_ACK;
                            end else if (st_q == ST_REG) begin
                                ptr_q <= shift_q;
                                st_q  <= ST_REG_ACK;
                            end else begin
                                st_q <= ST_WDATA_ACK;
                            end
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        if (rw_q) begin
                            shift_q   <= {rd_byte[6:0], 1'b0};
                            sda_drv_q <= ~rd_byte[7];
                            cnt_q     <= 4'h1;
                            st_q      <= ST_RDATA;
                        end else begin
                            sda_drv_q <= 1'b0;
                            st_q      <= ST_REG;
                        end
                    end
                end
                ST_REG_ACK, ST_WDATA_ACK: begin
                    if (scl_fall) begin
                        sda_drv_q <= 1'b0;
                        if (st_q == ST_WDATA_ACK) begin
                            ptr_q <= ptr_q + 8'h01;
                        end
                        st_q <= ST_WDATA;
                    end
                end
                ST_RDATA: begin
                    if (byte_end) begin
                        sda_drv_q <= 1'b0;
                        ptr_q     <= ptr_q + 8'h01;
                        st_q      <= ST_RDATA_ACK;
                    end else if (scl_fall) begin
                        sda_drv_q <= ~shift_q[7];
                        shift_q   <= {shift_q[6:0], 1'b0};
                        cnt_q     <= cnt_q + 4'h1;
                    end
                end
                ST_RDATA_ACK: begin
                    if (scl_rise) begin
                        mack_q <= ~sda_s;
                    end else if (scl_fall) begin
                        if (mack_q) begin
                            shift_q   <= {rd_byte[6:0], 1'b0};
                            sda_drv_q <= ~rd_byte[7];
                            cnt_q     <= 4'h1;
                            st_q      <= ST_RDATA;
                        end else begin
                            st_q <= ST_IDLE;
                        end
                    end
                end
            endcase
        end
    end

    // Only ever pulls low; the pad never sources a high level. [RL10]
    assign SDA_O  = 1'b0;
    assign SDA_OE = sda_drv_q;

    ////////////////////////////////////////////////////////////////////////
    // Registers.

    logic [7:0] mask_q;
    logic [7:0] flags_q;
    logic [7:0] status;
    logic [7:0] snap_q;
    logic       snap_vld_q;
    logic [7:0] flag_set;
    logic [7:0] flag_clr;
    logic       irq_q;

    assign status = {4'h0, ~irq_line_s, shutdown_q, warn_s, shdn_s};

    always_comb begin
        unique case (ptr_q)
            REG_MASK_ADDR: rd_byte = mask_q;
            REG_STAT_ADDR: rd_byte = status;
            REG_FLAG_ADDR: rd_byte = flags_q;
            default:       rd_byte = 8'h00;
        endcase
    end

    always_ff @(posedge MCLK) begin
        if (RST) begin
            mask_q <= MASK_RESET;
        end else if (wr_p && ptr_q == REG_MASK_ADDR) begin
            mask_q <= shift_q; // [RL3] [RL4]
        end
    end

    // The snapshot taken at byte load limits the clear to bits the host
    // actually saw, so an event arriving mid-transfer survives the read.
    always_ff @(posedge MCLK) begin
        if (RST) begin
            snap_q     <= 8'h00;
            snap_vld_q <= 1'b0;
        end else if (load_p) begin
            snap_q     <= flags_q;
            snap_vld_q <= (ptr_q == REG_FLAG_ADDR);
        end else if (i2c_start || i2c_stop || rd_done_p) begin
            snap_vld_q <= 1'b0;
        end
    end

    assign rd_done_p = byte_end && (st_q == ST_RDATA) && snap_vld_q;

    always_comb begin
        flag_set           = 8'h00;
        flag_set[BIT_SHDN] = shdn_rise;
        flag_set[BIT_WARN] = warn_rise; // [RL6]
    end

    assign flag_clr = rd_done_p ? snap_q : 8'h00; // [RL1]

    always_ff @(posedge MCLK) begin
        if (RST) begin
            flags_q <= FLAG_RESET;
        end else begin
            flags_q <= ((flags_q & ~flag_clr) | flag_set) & FLAG_USED; // [RL1] [RL5] [RL11]
        end
    end

    // Request follows pending unmasked flags, so clearing by read releases it.
    always_ff @(posedge MCLK) begin
        if (RST) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(flags_q & ~mask_q & FLAG_USED); // [RL2] [RL3] [RL4] [RL6] [RL11]
        end
    end

    assign IRQ_N_O  = 1'b0;
    assign IRQ_N_OE = irq_q; // [RL10]

    ////////////////////////////////////////////////////////////////////////
    // Checks.

    AST_READ_CLEARS: assert property (@(posedge MCLK) disable iff (RST) // [RL1]
        (rd_done_p && flag_set == 8'h00) |=> ((flags_q & $past(snap_q)) == 8'h00))
        else $error("Flag register bits survived a completed read.");

    AST_READ_RELEASES: assert property (@(posedge MCLK) disable iff (RST) // [RL2]
        (rd_done_p && flags_q == snap_q && flag_set == 8'h00) ##1 (flag_set == 8'h00) |=> !IRQ_N_OE)
        else $error("Interrupt line not released after flag read.");

    AST_SHDN_UNMASKED: assert property (@(posedge MCLK) disable iff (RST) // [RL3]
        (shdn_rise && !mask_q[BIT_SHDN] && !rd_done_p) |=> ##1 IRQ_N_OE)
        else $error("Unmasked shutdown trip did not assert the request.");

    AST_WARN_UNMASKED: assert property (@(posedge MCLK) disable iff (RST) // [RL4]
        (warn_rise && !mask_q[BIT_WARN] && !rd_done_p) |=> ##1 IRQ_N_OE)
        else $error("Unmasked warning did not assert the request.");

    AST_WARN_ZERO_CAUSE: assert property (@(posedge MCLK) disable iff (RST) // [RL5]
        $rose(flags_q[BIT_WARN]) |-> $past(warn_rise))
        else $error("Warning flag set without a warning event.");

    AST_WARN_RECORDS: assert property (@(posedge MCLK) disable iff (RST) // [RL6]
        warn_rise |=> flags_q[BIT_WARN] && status[BIT_WARN])
        else $error("Warning event not recorded in flag and status.");

    AST_MASKED_QUIET: assert property (@(posedge MCLK) disable iff (RST) // [RL11]
        ((flags_q & ~mask_q & FLAG_USED) == 8'h00) |=> !IRQ_N_OE)
        else $error("Request asserted with only masked flags pending.");

    AST_SDA_OWN_SLOT: assert property (@(posedge MCLK) disable iff (RST) // [RL10]
        SDA_OE |-> (st_q inside {ST_ADDR_ACK, ST_REG_ACK, ST_WDATA_ACK, ST_RDATA}))
        else $error("Data line pulled low outside an acknowledge or read slot.");

endmodule

//--- sim/tmi_host.sv
`timescale 1ns/1ns
module tmi_host (
    input  wire logic       mclk,
    input  wire logic       sda_line,
    output logic            scl,
    output logic            sda_pull,
    output logic            rd_done,
    output logic [7:0]      rd_byte
);
    import tmi_pkg::*;

    // The host only ever pulls SDA low; the bench adds the pull-up.
    initial begin
        scl      = 1'b1;
        sda_pull = 1'b0;
        rd_done  = 1'b0;
        rd_byte  = 8'h00;
    end

    task automatic wait_n(input int n);
        repeat (n) @(negedge mclk);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic start_cond();
        sda_pull = 1'b0;
        wait_n(10);
        scl = 1'b1;
        wait_n(10);
        sda_pull = 1'b1;
        wait_n(10);
        scl = 1'b0;
        wait_n(2);
    endtask

    task automatic stop_cond();
        sda_pull = 1'b1;
        wait_n(10);
        scl = 1'b1;
        wait_n(10);
        sda_pull = 1'b0;
        wait_n(10);
    endtask

    // Data moves only after SCL has been low for two cycles, so it never
    // looks like a start or stop to the device's synchronisers.
    task automatic clock_bit(input logic b, output logic s);
        sda_pull = ~b;
        wait_n(10);
        scl = 1'b1;
        wait_n(6);
        s = sda_line;
        wait_n(6);
        scl = 1'b0;
        wait_n(2);
    endtask

    task automatic xfer_byte(input logic [7:0] tx, input logic ack_bit, output logic [7:0] rx);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            clock_bit(tx[i], s);
            rx[i] = s;
        end
        clock_bit(ack_bit, s);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic write_reg(input logic [6:0] dev, input logic [7:0] ra, input logic [7:0] wd);
        logic [7:0] rx;
        start_cond();
        xfer_byte({dev, 1'b0}, 1'b1, rx);
        xfer_byte(ra, 1'b1, rx);
        xfer_byte(wd, 1'b1, rx);
        stop_cond();
    endtask

    // Two data bytes in one frame exercise the register pointer increment.
    task automatic write_pair(input logic [6:0] dev, input logic [7:0] ra, input logic [7:0] w0,
                              input logic [7:0] w1);
        logic [7:0] rx;
        start_cond();
        xfer_byte({dev, 1'b0}, 1'b1, rx);
        xfer_byte(ra, 1'b1, rx);
        xfer_byte(w0, 1'b1, rx);
        xfer_byte(w1, 1'b1, rx);
        stop_cond();
    endtask

    // Single-byte read ending in a nack, as the host does after a request.
    task automatic read_reg(input logic [6:0] dev, input logic [7:0] ra);
        logic [7:0] rx;
        start_cond();
        xfer_byte({dev, 1'b0}, 1'b1, rx);
        xfer_byte(ra, 1'b1, rx);
        start_cond();
        xfer_byte({dev, 1'b1}, 1'b1, rx);
        xfer_byte(8'hff, 1'b1, rx);
        rd_byte = rx;
        rd_done = 1'b1;
        wait_n(1);
        rd_done = 1'b0;
        stop_cond();
    endtask
endmodule

//--- sim/testbench.sv
`timescale 1ns/1ns
module testbench;
    import tmi_pkg::*;

    logic       mclk = 1'b0;
    logic       rst;
    logic       scl;
    logic       sda_pull;
    logic       sda_line;
    logic       sda_o;
    logic       sda_oe;
    logic       irq_line;
    logic       irq_n_o;
    logic       irq_n_oe;
    logic       hot_warn;
    logic       hot_trip;
    logic       cool_ok;
    logic       pwr_up_req;
    logic       pwr_up_go;
    logic       emerg_shdn;
    logic       rd_done;
    logic [7:0] rd_byte;
    logic       snap;
    logic [5:0] go_cnt;
    logic [7:0] exp_q[$];
    string      what_q[$];
    int         miscompares = 0;
    int         cmp_count = 0;

    always #4 mclk = ~mclk;

    // Both lines are open drain with pull-ups.
    assign sda_line = ~(sda_pull | (sda_oe & ~sda_o));
    assign irq_line = ~(irq_n_oe & ~irq_n_o);

    tmi_top dut (
        .MCLK       (mclk),
        .RST        (rst),
        .SCL_I      (scl),
        .SDA_I      (sda_line),
        .SDA_O      (sda_o),
        .SDA_OE     (sda_oe),
        .IRQ_N_I    (irq_line),
        .IRQ_N_O    (irq_n_o),
        .IRQ_N_OE   (irq_n_oe),
        .HOT_WARN   (hot_warn),
        .HOT_TRIP   (hot_trip),
        .COOL_OK    (cool_ok),
        .PWR_UP_REQ (pwr_up_req),
        .PWR_UP_GO  (pwr_up_go),
        .EMERG_SHDN (emerg_shdn)
    );

    tmi_host host (
        .mclk     (mclk),
        .sda_line (sda_line),
        .scl      (scl),
        .sda_pull (sda_pull),
        .rd_done  (rd_done),
        .rd_byte  (rd_byte)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
        if (miscompares == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic take(input logic [7:0] got);
        cmp_count++;
        if (exp_q.size() == 0) begin
            miscompares++;
            $display("CHECK FAILED result without note expected none seen %h", got);
        end else if (exp_q[0] !== got) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what_q[0], exp_q[0], got);
        end
        if (exp_q.size() > 0) begin
            void'(exp_q.pop_front());
            void'(what_q.pop_front());
        end
    endtask

    // The pulse output is counted so that a one-cycle pulse can be judged later.
    always @(posedge mclk) begin
        if (rst)
            go_cnt <= 6'h00;
        else if (pwr_up_go === 1'b1)
            go_cnt <= go_cnt + 6'h01;
    end

    always @(posedge mclk) begin
        if (rd_done === 1'b1)
            take(rd_byte);
        if (snap === 1'b1)
            take({go_cnt, emerg_shdn, irq_n_oe});
        if (rst === 1'b0 && (sda_o !== 1'b0 || irq_n_o !== 1'b0)) begin
            miscompares++;
            $display("CHECK FAILED open drain level expected 0 seen %b", {sda_o, irq_n_o});
        end
    end

    task automatic rd_chk(input string what, input logic [7:0] ra, input logic [7:0] exp);
        what_q.push_back(what);
        exp_q.push_back(exp);
        host.read_reg(DEV_ADDR_DFLT, ra);
    endtask

    task automatic pin_chk(input string what, input logic [7:0] exp);
        what_q.push_back(what);
        exp_q.push_back(exp);
        @(negedge mclk);
        snap = 1'b1;
        @(negedge mclk);
        snap = 1'b0;
    endtask

    task automatic pulse_req();
        pwr_up_req = 1'b1;
        repeat (10) @(negedge mclk);
        pwr_up_req = 1'b0;
        repeat (10) @(negedge mclk);
    endtask

    initial begin
        repeat (100000) @(posedge mclk);
        miscompares++;
        $display("CHECK FAILED run length expected end seen limit");
        close_out();
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        logic [7:0] rnd;
        logic [7:0] mval;
        logic [7:0] sts;
        logic [5:0] gexp;
        logic       shdn;
        logic       irq;
        int         b;
        rst = 1'b1;
        snap = 1'b0;
        hot_warn = 1'b0;
        hot_trip = 1'b0;
        cool_ok = 1'b0;
        pwr_up_req = 1'b0;
        gexp = 6'h00;
        void'($urandom(2683));
        repeat (5) @(negedge mclk);
        rst = 1'b0;
        repeat (5) @(negedge mclk);
        pin_chk("pins after reset", 8'h00);
        rd_chk("mask reset", REG_MASK_ADDR, MASK_RESET);
        rd_chk("flags reset", REG_FLAG_ADDR, FLAG_RESET);
        rd_chk("unmapped register", 8'h20, 8'h00);
        rnd = 8'($urandom());
        host.write_reg(DEV_ADDR_DFLT, REG_MASK_ADDR, rnd);
        rd_chk("mask readback", REG_MASK_ADDR, rnd);
        host.write_reg(~DEV_ADDR_DFLT, REG_MASK_ADDR, ~rnd);
        rd_chk("mask after foreign address", REG_MASK_ADDR, rnd);
        host.write_pair(DEV_ADDR_DFLT, REG_MASK_ADDR - 8'h01, rnd, ~rnd);
        rd_chk("mask after burst write", REG_MASK_ADDR, ~rnd);
        // Each source once unmasked and once masked, upper mask bits random.
        for (int k = 0; k < 4; k++) begin
            b = (k < 2) ? BIT_WARN : BIT_SHDN;
            mval = {rnd[7:2], 2'b00};
            mval[b] = k[0];
            shdn = (b == BIT_SHDN);
            irq = ~k[0];
            host.write_reg(DEV_ADDR_DFLT, REG_MASK_ADDR, mval);
            hot_warn = ~shdn;
            hot_trip = shdn;
            repeat (10) @(negedge mclk);
            pin_chk("pins after event", {gexp, shdn, irq});
            sts = 8'h00;
            sts[b] = 1'b1;
            sts[BIT_LATCH] = shdn;
            sts[BIT_IRQ_LINE] = irq;
            rd_chk("status after event", REG_STAT_ADDR, sts);
            rd_chk("flags after event", REG_FLAG_ADDR, 8'h01 << b);
            pin_chk("pins after flag read", {gexp, shdn, 1'b0});
            rd_chk("flags after clear", REG_FLAG_ADDR, 8'h00);
            hot_warn = 1'b0;
            hot_trip = 1'b0;
            if (shdn) begin
                pulse_req();
                pin_chk("power-up while hot", {gexp, 1'b1, 1'b0});
                cool_ok = 1'b1;
                pulse_req();
                cool_ok = 1'b0;
                gexp = gexp + 6'h01;
                pin_chk("power-up when cool", {gexp, 1'b0, 1'b0});
            end
        end
        repeat (10) @(negedge mclk);
        if (exp_q.size() != 0) begin
            miscompares++;
            $display("CHECK FAILED pending notes expected 0 seen %0d", exp_q.size());
        end
        close_out();
    end
endmodule
